// ### src/vme_slave_pkg.sv
package vme_slave_pkg;

	// local processor control write addresses
	localparam logic [31:0] ENABLE_CTL_ADDR = 32'hFE384003;
	localparam logic [31:0] ENABLE_OFF_ADDR = 32'hFE384002;
	localparam logic [31:0] SLAVE_IF_CTL_ADDR = 32'hFE388000;
	localparam logic [31:0] PRIMARY_CTL_ADDR = 32'hFE38C000;
	localparam logic [31:0] EXTENDED_CTL_ADDR = 32'hFE3A0000;
	localparam logic [31:0] PRIMARY_MODE_ADDR = 32'hFE380003;

	// slave interface control sub-locations (low address bits)
	localparam logic [3:0] SIC_A32_SEL = 4'h0;
	localparam logic [3:0] SIC_A24_SEL = 4'h1;
	localparam logic [3:0] SIC_SUPV_ON = 4'h2;
	localparam logic [3:0] SIC_SUPV_OFF = 4'h3;
	localparam logic [3:0] SIC_BCAST_OFF = 4'h4;
	localparam logic [3:0] SIC_BCAST_ON = 4'h5;
	// base bit locations: offset 0x10 + 2*bit (+1 sets); bits 31..20
	localparam logic [7:0] BASE_LOC_START = 8'h10;
	localparam int BASE_LSB = 20;
	localparam int BASE_BITS = 12;

	// memory protect data codes
	localparam logic [7:0] PROTECT_OFF_CODE = 8'h05;
	localparam logic [7:0] PROTECT_ON_CODE = 8'h0D;

	// installed size codes 0..7 = 4..512 MB
	localparam logic [2:0] SIZE_RESET = 3'h0;
	localparam logic [BASE_BITS-1:0] BASE_RESET = 12'h000;
	localparam logic [31:0] REMOTE_RESET_BLOCK_OFS = 32'h0003FE00;

	// supervisory and user address modifiers
	localparam logic [5:0] AM_A32_SUP_DATA = 6'h0D;
	localparam logic [5:0] AM_A32_SUP_BLT = 6'h0F;
	localparam logic [5:0] AM_A32_SUP_MBLT = 6'h0C;
	localparam logic [5:0] AM_A32_USR_DATA = 6'h09;
	localparam logic [5:0] AM_A32_USR_BLT = 6'h0B;
	localparam logic [5:0] AM_A32_USR_MBLT = 6'h08;
	localparam logic [5:0] AM_A24_SUP_DATA = 6'h3D;
	localparam logic [5:0] AM_A24_SUP_BLT = 6'h3F;
	localparam logic [5:0] AM_A24_SUP_MBLT = 6'h3C;
	localparam logic [5:0] AM_A24_USR_DATA = 6'h39;
	localparam logic [5:0] AM_A24_USR_BLT = 6'h3B;
	localparam logic [5:0] AM_A24_USR_MBLT = 6'h38;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_REQ = 5'b00010,
		ST_ACK = 5'b00100,
		ST_WAIT = 5'b01000,
		ST_RST = 5'b10000
	} slave_state_type;

	typedef struct packed {
		logic [31:0] addr;
		logic [5:0] am;
		logic [3:0] be;
		logic write;
	} vme_cycle_type;

	typedef struct packed {
		logic [31:0] addr;
		logic [63:0] wdata;
		logic [7:0] be;
		logic write;
	} ram_req_type;

endpackage : vme_slave_pkg

// ### src/vme_slave_ram_port.sv
`timescale 1ns/1ps
// Function
// - decode A32 or A24, one at a time
// - complete D32, D16, D8 single transfers
// - accept MBLT and BLT, advancing address
// - window base programmable over 4 GB
// - window sizes 4 to 512 MB
// - window A32/A24, D32/D16, or disabled
// - enable location turns port on/off
// - disabled after reset; settings back to reset values
// - default: writes only from supervisor
// - reset: A32, base zero, broadcast off
// - supervisor write to reset block resets
// - remote reset only with strap installed
// - interface control: mode, supervisor, base
// - primary/extended: protect, upper base
// - arbitrate slave against other RAM users
// - byte writes select A24 / restore A32
// - supervisor decision from address modifier
// - 0D blocks writes, 05 re-allows
module vme_slave_ram_port
	import vme_slave_pkg::*;
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// board strap and installed size
	input wire logic i_remote_reset_strap,
	input wire logic [2:0] i_mem_size,
	// local cpu control writes
	input wire logic i_cpu_wr,
	input wire logic [31:0] i_cpu_addr,
	input wire logic [7:0] i_cpu_wdata,
	// vme slave side, AS and DS synchronised here
	input wire logic i_vme_as_n,
	input wire logic i_vme_ds_n,
	input wire logic i_vme_d16,
	input wire vme_cycle_type i_vme_cycle,
	input wire logic [63:0] i_vme_wdata,
	output logic o_vme_dtack_n,
	output logic [63:0] o_vme_rdata,
	// ram arbiter
	output ram_req_type o_ram_req,
	output logic o_ram_req_valid,
	input wire logic i_ram_grant,
	input wire logic i_ram_done,
	input wire logic [63:0] i_ram_rdata,
	// board reset request and status
	output logic o_board_reset,
	output logic o_slave_enabled,
	output logic o_bcast_en
);

	logic [2:0] as_sync_ff, ds_sync_ff;
	logic [2:0] nxt_as_sync, nxt_ds_sync;
	logic as_ff, ds_ff, nxt_as, nxt_ds;
	logic en_ff, a24_ff, supv_ff, prot_ff, bcast_ff, d16_ff;
	logic nxt_en, nxt_a24, nxt_supv, nxt_prot, nxt_bcast, nxt_d16;
	logic [BASE_BITS-1:0] base_ff, nxt_base;
	logic strap_ff, nxt_strap;
	slave_state_type state_ff, nxt_state;
	ram_req_type req_ff, nxt_req;
	logic req_valid_ff, nxt_req_valid;
	logic dtack_n_ff, nxt_dtack_n;
	logic [63:0] rdata_ff, nxt_rdata;
	logic rst_out_ff, nxt_rst_out;
	logic [31:0] beat_addr_ff, nxt_beat_addr;
	logic in_burst_ff, nxt_in_burst;

	logic [31:0] win_mask, rel_addr, eff_addr, rst_ofs;
	logic is_sup, is_a32_am, is_a24_am, is_mblt, is_blt;
	logic hit, wr_ok, is_rst_wr, sic_hit, ext_hit;
	logic [7:0] loc;

	// pin inputs: three stages, accept a change when stages 2 and 3 agree
	always_comb begin
		nxt_as_sync = {as_sync_ff[1:0], ~i_vme_as_n};
		nxt_ds_sync = {ds_sync_ff[1:0], ~i_vme_ds_n};
		nxt_as = (as_sync_ff[2] == as_sync_ff[1]) ? as_sync_ff[2] : as_ff;
		nxt_ds = (ds_sync_ff[2] == ds_sync_ff[1]) ? ds_sync_ff[2] : ds_ff;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			as_sync_ff <= 3'h0;
			ds_sync_ff <= 3'h0;
			as_ff <= 1'b0;
			ds_ff <= 1'b0;
		end else begin
			as_sync_ff <= nxt_as_sync;
			ds_sync_ff <= nxt_ds_sync;
			as_ff <= nxt_as;
			ds_ff <= nxt_ds;
		end
	end

	// control locations, written by the local processor
	always_comb begin
		loc = i_cpu_addr[7:0];
		sic_hit = i_cpu_addr[31:8] == SLAVE_IF_CTL_ADDR[31:8];
		ext_hit = i_cpu_addr[31:8] == EXTENDED_CTL_ADDR[31:8];
		nxt_en = en_ff;
		nxt_a24 = a24_ff;
		nxt_supv = supv_ff;
		nxt_prot = prot_ff;
		nxt_bcast = bcast_ff;
		nxt_d16 = d16_ff;
		// strap is sampled every cycle after release, never at reset
		nxt_strap = i_remote_reset_strap;
		if (i_cpu_wr) begin
			if (i_cpu_addr == ENABLE_CTL_ADDR)
				nxt_en = 1'b1;
			if (i_cpu_addr == ENABLE_OFF_ADDR)
				nxt_en = 1'b0;
			if (sic_hit && loc[3:0] == SIC_A24_SEL && loc[7:4] == 4'h0)
				nxt_a24 = 1'b1;
			if (sic_hit && loc[3:0] == SIC_A32_SEL && loc[7:4] == 4'h0)
				nxt_a24 = 1'b0;
			if (sic_hit && loc == {4'h0, SIC_SUPV_ON})
				nxt_supv = 1'b1;
			if (sic_hit && loc == {4'h0, SIC_SUPV_OFF})
				nxt_supv = 1'b0;
			if (sic_hit && loc == {4'h0, SIC_BCAST_ON})
				nxt_bcast = 1'b1;
			if (sic_hit && loc == {4'h0, SIC_BCAST_OFF})
				nxt_bcast = 1'b0;
			// primary control picks window data width
			if (i_cpu_addr[31:8] == PRIMARY_CTL_ADDR[31:8])
				nxt_d16 = loc[0];
			if (i_cpu_addr == PRIMARY_MODE_ADDR && i_cpu_wdata == PROTECT_ON_CODE)
				nxt_prot = 1'b1;
			if (i_cpu_addr == PRIMARY_MODE_ADDR && i_cpu_wdata == PROTECT_OFF_CODE)
				nxt_prot = 1'b0;
		end
	end

	// base bits: low half via interface ctl, upper via extended ctl
	genvar gb;
	generate
		for (gb = 0; gb < BASE_BITS; gb++) begin : g_base
			localparam logic [7:0] LOC_CLR = BASE_LOC_START + 8'(2 * gb);
			always_comb begin
				nxt_base[gb] = base_ff[gb];
				if (i_cpu_wr && (gb < 6 ? sic_hit : ext_hit) && loc[7:1] == LOC_CLR[7:1])
					nxt_base[gb] = loc[0];
			end
		end
	endgenerate

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			en_ff <= 1'b0;
			a24_ff <= 1'b0;
			base_ff <= BASE_RESET;
			bcast_ff <= 1'b0;
			supv_ff <= 1'b1;
			prot_ff <= 1'b0;
			d16_ff <= 1'b0;
			strap_ff <= 1'b0;
		end else begin
			en_ff <= nxt_en;
			a24_ff <= nxt_a24;
			supv_ff <= nxt_supv;
			prot_ff <= nxt_prot;
			bcast_ff <= nxt_bcast;
			d16_ff <= nxt_d16;
			base_ff <= nxt_base;
			strap_ff <= nxt_strap;
		end
	end

	// slave decode
	always_comb begin
		// window equals installed size, 4 MB << code
		win_mask = 32'(32'h003FFFFF << i_mem_size) | 32'h003FFFFF;
		is_a32_am = i_vme_cycle.am[5:4] == 2'h0;
		is_a24_am = i_vme_cycle.am[5:4] == 2'h3;
		is_sup = i_vme_cycle.am[2];
		is_mblt = i_vme_cycle.am[1:0] == 2'h0;
		is_blt = i_vme_cycle.am[1:0] == 2'h3;
		rel_addr = a24_ff ? {8'h00, i_vme_cycle.addr[23:0]} : i_vme_cycle.addr;
		hit = en_ff && (a24_ff ? is_a24_am : is_a32_am);
		if (a24_ff)
			hit = hit && ((rel_addr[23:20] & ~win_mask[23:20]) == (base_ff[3:0] & ~win_mask[23:20]));
		else
			hit = hit && ((rel_addr[31:20] & ~win_mask[31:20]) == (base_ff & ~win_mask[31:20]));
		// 16-bit window refuses 32-bit lanes and MBLT
		if (d16_ff && (&i_vme_cycle.be || is_mblt))
			hit = 1'b0;
		eff_addr = rel_addr & win_mask;
		wr_ok = !prot_ff && (!supv_ff || is_sup);
		rst_ofs = (win_mask + 32'h1) - 32'h200;
		is_rst_wr = strap_ff && is_sup && i_vme_cycle.write && eff_addr == rst_ofs;
	end

	// transfer engine
	always_comb begin
		nxt_state = state_ff;
		nxt_req = req_ff;
		nxt_req_valid = 1'b0;
		nxt_dtack_n = dtack_n_ff;
		nxt_rdata = rdata_ff;
		nxt_rst_out = 1'b0;
		nxt_beat_addr = beat_addr_ff;
		nxt_in_burst = in_burst_ff;
		case (state_ff)
			ST_IDLE: begin
				nxt_dtack_n = 1'b1;
				if (!as_ff)
					nxt_in_burst = 1'b0;
				if (as_ff && ds_ff && hit) begin
					if (i_vme_cycle.write && !wr_ok) begin
						nxt_state = ST_WAIT;
					end else if (is_rst_wr) begin
						nxt_state = ST_RST;
					end else begin
						nxt_beat_addr = in_burst_ff ? beat_addr_ff : eff_addr;
						nxt_req.addr = in_burst_ff ? beat_addr_ff : eff_addr;
						// byte lanes give D8, D16 or D32
						nxt_req.be = is_mblt ? 8'hFF : {4'h0, i_vme_cycle.be};
						nxt_req.wdata = i_vme_wdata;
						nxt_req.write = i_vme_cycle.write;
						nxt_req_valid = 1'b1;
						nxt_state = ST_REQ;
					end
				end
			end
			ST_REQ: begin
				// hold request until arbiter grants
				// once granted it stays low, else the arbiter would serve a second access
				nxt_req_valid = req_valid_ff && !i_ram_grant;
				if (i_ram_done) begin
					nxt_rdata = i_ram_rdata;
					nxt_dtack_n = 1'b0;
					nxt_state = ST_ACK;
					if (is_mblt || is_blt) begin
						nxt_in_burst = 1'b1;
						nxt_beat_addr = beat_addr_ff + (is_mblt ? 32'h8 : 32'h4);
					end
				end
			end
			ST_ACK: begin
				if (!ds_ff) begin
					nxt_dtack_n = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
			ST_WAIT: begin
				// blocked write: stay silent, bus timer ends the cycle
				if (!ds_ff)
					nxt_state = ST_IDLE;
			end
			ST_RST: begin
				nxt_rst_out = 1'b1;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			state_ff <= ST_IDLE;
			req_ff <= '0;
			req_valid_ff <= 1'b0;
			dtack_n_ff <= 1'b1;
			rdata_ff <= 64'h0;
			rst_out_ff <= 1'b0;
			beat_addr_ff <= 32'h0;
			in_burst_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			req_ff <= nxt_req;
			req_valid_ff <= nxt_req_valid;
			dtack_n_ff <= nxt_dtack_n;
			rdata_ff <= nxt_rdata;
			rst_out_ff <= nxt_rst_out;
			beat_addr_ff <= nxt_beat_addr;
			in_burst_ff <= nxt_in_burst;
		end
	end

	assign o_vme_dtack_n = dtack_n_ff;
	assign o_vme_rdata = rdata_ff;
	assign o_ram_req = req_ff;
	assign o_ram_req_valid = req_valid_ff;
	assign o_board_reset = rst_out_ff;
	assign o_slave_enabled = en_ff;
	assign o_bcast_en = bcast_ff;

endmodule : vme_slave_ram_port

// ### dv/vme_slave_ram_port_monitor.sv
`timescale 1ns/1ps
module vme_slave_ram_port_monitor
	import vme_slave_pkg::*;
(
	// inputs seen
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic i_vme_ds_n,
	input wire logic i_cpu_wr,
	input wire logic [31:0] i_cpu_addr,
	input wire logic i_ram_done,
	input wire logic i_ram_grant,
	// outputs seen
	input wire logic o_vme_dtack_n,
	input wire logic o_ram_req_valid,
	input wire logic o_board_reset,
	input wire logic o_slave_enabled,
	input wire logic o_bcast_en
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	// three sync flops, the accept flop, the release cycle and the sampling cycle; no margin
	sequence s_ds_idle;
		i_vme_ds_n [*6];
	endsequence
	property p_rst;
		$fell(i_sys_rst) |-> o_vme_dtack_n && !o_ram_req_valid && !o_slave_enabled
			&& !o_bcast_en && !o_board_reset;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not at reset state");
	property p_en_on;
		i_cpu_wr && i_cpu_addr == ENABLE_CTL_ADDR |=> o_slave_enabled;
	endproperty
	a_en_on: assert property (p_en_on) else $error("port not enabled");
	property p_bcast;
		i_cpu_wr && i_cpu_addr == SLAVE_IF_CTL_ADDR + 32'h5 |=> o_bcast_en;
	endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast not set");
	property p_ack_en;
		$fell(o_vme_dtack_n) |-> $past(o_slave_enabled);
	endproperty
	a_ack_en: assert property (p_ack_en) else $error("ack while disabled");
	property p_done_ack;
		i_ram_done |=> !o_vme_dtack_n;
	endproperty
	a_done_ack: assert property (p_done_ack) else $error("no ack after done");
	property p_release;
		s_ds_idle |-> o_vme_dtack_n;
	endproperty
	a_release: assert property (p_release) else $error("ack held too long");
	property p_req_hold;
		o_ram_req_valid && !i_ram_grant |=> o_ram_req_valid;
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request dropped");
	property p_brst_hold;
		o_board_reset |=> o_board_reset;
	endproperty
	a_brst_hold: assert property (p_brst_hold) else $error("board reset dropped");
endmodule : vme_slave_ram_port_monitor

bind vme_slave_ram_port vme_slave_ram_port_monitor i_mon (
	.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_vme_ds_n(i_vme_ds_n),
	.i_cpu_wr(i_cpu_wr), .i_cpu_addr(i_cpu_addr), .i_ram_done(i_ram_done),
	.i_ram_grant(i_ram_grant), .o_vme_dtack_n(o_vme_dtack_n),
	.o_ram_req_valid(o_ram_req_valid), .o_board_reset(o_board_reset),
	.o_slave_enabled(o_slave_enabled), .o_bcast_en(o_bcast_en)
);

// ### dv/ram_partner.sv
`timescale 1ns/1ps
module ram_partner #(
	parameter logic [63:0] RD_PAT = 64'h0123456789ABCDEF
) (
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic i_req_valid,
	output logic o_grant,
	output logic o_done,
	output logic [63:0] o_rdata
);
	logic [2:0] cnt_ff;
	logic busy_ff;
	logic slow_ff;
	logic pend_ff;
	always_ff @(posedge i_sys_clk) begin
		o_grant <= 1'h0;
		o_done <= 1'h0;
		// idle data is inverted so a stale value never looks valid
		o_rdata <= ~RD_PAT;
		if (i_sys_rst) begin
			busy_ff <= 1'h0;
			slow_ff <= 1'h0;
			pend_ff <= 1'h0;
			cnt_ff <= 3'h0;
		end else begin
			if (!busy_ff && i_req_valid && !o_grant) begin
				busy_ff <= 1'h1;
				cnt_ff <= slow_ff ? 3'h5 : 3'h0;
				slow_ff <= !slow_ff;
			end else if (busy_ff && cnt_ff != 3'h0) begin
				cnt_ff <= cnt_ff - 3'h1;
			end else if (busy_ff) begin
				busy_ff <= 1'h0;
				o_grant <= 1'h1;
				pend_ff <= 1'h1;
			end
			if (pend_ff) begin
				pend_ff <= 1'h0;
				o_done <= 1'h1;
				o_rdata <= RD_PAT;
			end
		end
	end
endmodule : ram_partner

// ### dv/tb_vme_slave_ram_port.sv
`timescale 1ns/1ps
module tb_vme_slave_ram_port
	import vme_slave_pkg::*;
;
	localparam logic [63:0] RDP = 64'hA5A55A5A0F0FF0F0;
	typedef struct packed {
		logic [31:0] a;
		logic [5:0] am;
		logic [3:0] be;
		logic w;
		logic ak;
	} row_type;
	row_type rows[6] = '{
		'{32'h10, AM_A32_SUP_DATA, 4'hF, 1'h0, 1'h1},
		'{32'h20, AM_A32_USR_DATA, 4'h1, 1'h0, 1'h1},
		'{32'h30, AM_A32_SUP_DATA, 4'h3, 1'h1, 1'h1},
		'{32'h40, AM_A32_USR_DATA, 4'hF, 1'h1, 1'h0},
		'{32'h50, AM_A24_SUP_DATA, 4'hF, 1'h0, 1'h0},
		'{32'h400000, AM_A32_SUP_DATA, 4'hF, 1'h0, 1'h0}};
	logic clk, rst, strap, cwr, as_n, ds_n, dtk_n, rqv, gnt, dn, brst, en, bc, ack;
	logic [31:0] ca;
	logic [2:0] msz;
	logic [7:0] cd;
	logic [63:0] wd, rd, rrd, rv;
	vme_cycle_type cyc;
	ram_req_type req;
	logic [31:0] ra[$];
	int n_errors = 0;
	int num_checks = 0;
	int tmo = 0;
	vme_slave_ram_port i_dut (.i_sys_clk(clk), .i_sys_rst(rst),
		.i_remote_reset_strap(strap), .i_mem_size(msz), .i_cpu_wr(cwr),
		.i_cpu_addr(ca), .i_cpu_wdata(cd), .i_vme_as_n(as_n), .i_vme_ds_n(ds_n),
		.i_vme_d16(1'h0), .i_vme_cycle(cyc), .i_vme_wdata(wd), .o_vme_dtack_n(dtk_n),
		.o_vme_rdata(rd), .o_ram_req(req), .o_ram_req_valid(rqv), .i_ram_grant(gnt),
		.i_ram_done(dn), .i_ram_rdata(rrd), .o_board_reset(brst),
		.o_slave_enabled(en), .o_bcast_en(bc));
	ram_partner #(.RD_PAT(RDP)) i_ram (.i_sys_clk(clk), .i_sys_rst(rst),
		.i_req_valid(rqv), .o_grant(gnt), .o_done(dn), .o_rdata(rrd));
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	task close_out;
		$display("errors %0d checks %0d", n_errors, num_checks);
		if (n_errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out
	// ceiling well above the ~1000 cycles the sequence needs
	always @(posedge clk) begin
		tmo++;
		if (tmo > 8000) begin
			n_errors++;
			close_out();
		end
		if (rqv && gnt) ra.push_back(req.addr);
	end
	task chk(input logic [63:0] s, input logic [63:0] e);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("wrong value at %0t: got %h exp %h", $time, s, e);
		end
	endtask : chk
	task cw(input logic [31:0] a, input logic [7:0] d);
		@(negedge clk);
		cwr = 1'h1;
		ca = a;
		cd = d;
		@(negedge clk);
		cwr = 1'h0;
	endtask : cw
	task vme(input logic [31:0] a, input logic [5:0] am, input logic [3:0] be,
		input logic w, input int nb);
		int k;
		@(negedge clk);
		cyc = '{a, am, be, w};
		wd = {a, ~a};
		as_n = 1'h0;
		repeat (nb) begin
			ds_n = 1'h0;
			for (k = 0; k < 40 && dtk_n !== 1'h0; k++) @(negedge clk);
			ack = (dtk_n === 1'h0);
			rv = rd;
			ds_n = 1'h1;
			@(negedge clk);
			for (k = 0; k < 40 && dtk_n !== 1'h1; k++) @(negedge clk);
		end
		as_n = 1'h1;
		repeat (6) @(negedge clk);
	endtask : vme
	initial begin
		{strap, cwr, ca, cd, cyc, wd, msz} = '0;
		{as_n, ds_n, rst} = 3'h7;
		repeat (5) @(negedge clk);
		rst = 1'h0;
		vme(32'h10, AM_A32_SUP_DATA, 4'hF, 1'h0, 1); chk(ack, 0);
		cw(ENABLE_CTL_ADDR, 8'h0);
		foreach (rows[i]) begin
			vme(rows[i].a, rows[i].am, rows[i].be, rows[i].w, 1);
			chk(ack, rows[i].ak);
			if (ack && !rows[i].w) chk(rv, RDP);
		end
		cw(PRIMARY_CTL_ADDR + 32'h1, 8'h0);
		vme(32'h10, AM_A32_SUP_DATA, 4'hF, 1'h0, 1); chk(ack, 0);
		vme(32'h10, AM_A32_SUP_DATA, 4'h3, 1'h0, 1); chk(ack, 1);
		cw(PRIMARY_CTL_ADDR, 8'h0);
		cw(PRIMARY_MODE_ADDR, PROTECT_ON_CODE);
		vme(32'h60, AM_A32_SUP_DATA, 4'hF, 1'h1, 1); chk(ack, 0);
		cw(PRIMARY_MODE_ADDR, PROTECT_OFF_CODE);
		vme(32'h60, AM_A32_SUP_DATA, 4'hF, 1'h1, 1); chk(ack, 1);
		cw(SLAVE_IF_CTL_ADDR + 32'h3, 8'h0);
		vme(32'h70, AM_A32_USR_DATA, 4'hF, 1'h1, 1); chk(ack, 1);
		ra.delete();
		vme(32'h100, AM_A32_SUP_BLT, 4'hF, 1'h0, 3); chk(ra[2] - ra[0], 8);
		ra.delete();
		vme(32'h200, AM_A32_SUP_MBLT, 4'hF, 1'h0, 2); chk(ra[1] - ra[0], 8);
		// base bit 22 moves the 4 MB window up by 4 MB; bits inside the size are not compared
		cw(SLAVE_IF_CTL_ADDR + 32'h15, 8'h0);
		vme(32'h10, AM_A32_SUP_DATA, 4'hF, 1'h0, 1); chk(ack, 0);
		vme(32'h400010, AM_A32_SUP_DATA, 4'hF, 1'h0, 1); chk(ack, 1);
		cw(SLAVE_IF_CTL_ADDR + 32'h1, 8'h0);
		vme(32'h400010, AM_A24_SUP_DATA, 4'hF, 1'h0, 1); chk(ack, 1);
		vme(32'h400010, AM_A32_SUP_DATA, 4'hF, 1'h0, 1); chk(ack, 0);
		cw(SLAVE_IF_CTL_ADDR, 8'h0);
		cw(ENABLE_OFF_ADDR, 8'h0);
		vme(32'h400010, AM_A32_SUP_DATA, 4'hF, 1'h0, 1); chk(ack, 0);
		cw(ENABLE_CTL_ADDR, 8'h0);
		vme(32'h400010, AM_A32_SUP_DATA, 4'hF, 1'h0, 1); chk(ack, 1);
		cw(SLAVE_IF_CTL_ADDR + 32'h5, 8'h0); chk(bc, 1);
		vme(32'h7FFE00, AM_A32_SUP_DATA, 4'h1, 1'h1, 1); chk(brst, 0);
		chk(ack, 1);
		strap = 1'h1;
		repeat (2) @(negedge clk);
		vme(32'h7FFE00, AM_A32_SUP_DATA, 4'h1, 1'h1, 1); chk(brst, 1);
		chk(ack, 0);
		rst = 1'h1;
		msz = 3'h1;
		repeat (5) @(negedge clk);
		rst = 1'h0;
		chk({brst, en, bc}, 0);
		cw(ENABLE_CTL_ADDR, 8'h0);
		vme(32'h10, AM_A32_SUP_DATA, 4'hF, 1'h0, 1); chk(ack, 1);
		vme(32'h7FFFF0, AM_A32_SUP_DATA, 4'hF, 1'h0, 1); chk(ack, 1);
		vme(32'h800010, AM_A32_SUP_DATA, 4'hF, 1'h0, 1); chk(ack, 0);
		close_out();
	end
endmodule : tb_vme_slave_ram_port
